// ### egress_cfg_pkg.sv
// Constants, types and map of the egress queue configuration block
package egress_cfg_pkg;
    localparam int          NUM_QUEUES    = 4;
    localparam int          APB_AW        = 18;
    localparam logic [3:0]  FIRST_PORT    = 4'h1;
    localparam logic [11:0] IDX_QSEL      = 12'h900;
    localparam logic [11:0] IDX_QSEL_BYTE = 12'h903;
    localparam logic [11:0] IDX_VIDREP    = 12'h904;
    localparam logic [11:0] IDX_QCOUNT    = 12'h90C;
    localparam logic [11:0] IDX_QCTRL0    = 12'h914;
    localparam logic [11:0] IDX_QCTRL1    = 12'h915;
    localparam logic [11:0] IDX_CRED_HI   = 12'h916;
    localparam logic [11:0] IDX_CRED_LO   = 12'h918;
    localparam logic [11:0] IDX_CRED_INC  = 12'h91A;
    localparam logic [6:0]  WEIGHT_RST    = 7'h01;
    localparam logic [15:0] CRED_HI_RST   = 16'h0534;
    localparam logic [15:0] CRED_LO_RST   = 16'h05F2;
    localparam logic [15:0] CRED_INC_RST  = 16'h2000;

    typedef enum logic [1:0] {
        SCHED_STRICT = 2'b00,
        SCHED_RSV1   = 2'b01,
        SCHED_WRR    = 2'b10,
        SCHED_RSV3   = 2'b11
    } sched_mode_t;

    typedef enum logic [1:0] {
        SHAPE_NONE = 2'b00,
        SHAPE_CBS  = 2'b01,
        SHAPE_RSV2 = 2'b10,
        SHAPE_RSV3 = 2'b11
    } shaper_mode_t;

    typedef enum logic [1:0] {
        QCNT_ONE  = 2'b00,
        QCNT_TWO  = 2'b01,
        QCNT_FOUR = 2'b10,
        QCNT_RSV  = 2'b11
    } qcount_t;

    typedef struct packed {
        sched_mode_t  sched;
        shaper_mode_t shaper;
        logic [6:0]   weight;
        logic [15:0]  credit_hi;
        logic [15:0]  credit_lo;
        logic [15:0]  credit_inc;
    } queue_cfg_t;

    localparam queue_cfg_t QUEUE_CFG_RST = '{
        SCHED_WRR, SHAPE_NONE, WEIGHT_RST,
        CRED_HI_RST, CRED_LO_RST, CRED_INC_RST};

    typedef struct packed {
        logic        valid;
        logic [1:0]  port;
        logic        double_tag;
        logic [11:0] outer_vid;
        logic [11:0] inner_vid;
    } egress_tag_t;
endpackage

// ### egress_sched.sv
// Per-port egress queue scheduler: strict priority or weighted round robin
`timescale 1ns/1ps
module egress_sched
    import egress_cfg_pkg::*;
(
    input  wire logic                      pclk,        // Core clock
    input  wire logic                      presetn,     // Async reset, low
    input  sched_mode_t                    mode,        // Port scheduler mode
    input  qcount_t                        qcount,      // Enabled queues
    input  wire logic [NUM_QUEUES-1:0][6:0] weights,    // Per-queue weight
    input  wire logic [NUM_QUEUES-1:0]     pending,     // Queue has a frame
    input  wire logic                      pick,        // Request a grant
    output logic                           grant_valid, // Grant pulse
    output logic [1:0]                     grant_queue  // Granted queue
);
    logic [1:0]            cur;
    logic [6:0]            sent;
    logic [NUM_QUEUES-1:0] mask;
    logic [NUM_QUEUES-1:0] avail;
    logic [1:0]            hi_q;
    logic [1:0]            rr_q;
    logic [1:0]            next_q;
    logic [6:0]            next_sent;
    logic                  stay;

    assign mask  = (qcount == QCNT_ONE) ? 4'h1 :
                   (qcount == QCNT_TWO) ? 4'h3 : 4'hF;
    assign avail = pending & mask;
    // Reserved mode codes behave as round robin, the reset policy
    assign stay  = avail[cur] && (sent < weights[cur]);

    always_comb begin
        hi_q = 2'h0;
        rr_q = cur;
        for (int i = 0; i < NUM_QUEUES; i++) begin
            if (avail[i]) hi_q = 2'(i);
        end
        // Nearest pending queue after cur; cur itself is the last resort
        for (int i = NUM_QUEUES; i >= 1; i--) begin
            if (avail[2'(cur + 2'(i))]) rr_q = 2'(cur + 2'(i));
        end
        case (mode)
            SCHED_STRICT: begin
                next_q    = hi_q;
                next_sent = 7'h00;
            end
            default: begin
                next_q    = stay ? cur : rr_q;
                next_sent = stay ? 7'(sent + 7'h01) : 7'h01;
            end
        endcase
        if (qcount == QCNT_ONE) begin
            next_q    = 2'h0;
            next_sent = 7'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur         <= 2'h0;
            sent        <= 7'h00;
            grant_valid <= 1'b0;
            grant_queue <= 2'h0;
        end else begin
            grant_valid <= pick && (|avail);
            if (pick && (|avail)) begin
                grant_queue <= next_q;
                cur         <= next_q;
                sent        <= next_sent;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pick_pending;
        pick && (|avail);
    endsequence
    // A pulse unless another pick was taken in the grant cycle
    sequence s_granted;
        grant_valid ##1 (!grant_valid || $past(pick));
    endsequence

    property p_grant_follows;
        s_pick_pending |=> s_granted;
    endproperty
    a_grant_follows: assert property (p_grant_follows)
        else $error("pick with pending queue gave no grant");

    property p_strict_top;
        (pick && mode == SCHED_STRICT && avail[3])
            |=> grant_valid && grant_queue == 2'h3;
    endproperty
    a_strict_top: assert property (p_strict_top)
        else $error("strict priority did not grant queue 3");

    property p_wrr_move;
        (pick && mode == SCHED_WRR && qcount != QCNT_ONE
         && sent >= weights[cur] && (avail & ~(4'h1 << cur)) != 4'h0)
            |=> grant_valid && grant_queue != $past(cur);
    endproperty
    a_wrr_move: assert property (p_wrr_move)
        else $error("round robin exceeded queue weight");

    property p_single_queue;
        (pick && qcount == QCNT_ONE && pending[0])
            |=> grant_valid && grant_queue == 2'h0;
    endproperty
    a_single_queue: assert property (p_single_queue)
        else $error("single queue port granted another queue");
endmodule

// ### egress_queue_sched_shaper_cfg.sv
// Egress queue config registers, VID replacement and per-port schedulers
`timescale 1ns/1ps
module egress_queue_sched_shaper_cfg
    import egress_cfg_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    input  wire logic                  pclk,             // Core clock
    input  wire logic                  presetn,          // Async reset, low
    input  wire logic                  psel,             // APB select
    input  wire logic                  penable,          // APB enable
    input  wire logic                  pwrite,           // APB direction
    input  wire logic [APB_AW-1:0]     paddr,            // APB byte address
    input  wire logic [31:0]           pwdata,           // APB write data
    input  wire logic [3:0]            pstrb,            // APB byte strobes
    output logic [31:0]                prdata,           // APB read data
    output logic                       pready,           // APB ready
    output logic                       pslverr,          // APB error
    input  wire logic [NUM_PORTS-1:0][11:0] port_default_vid, // Port VID
    input  egress_tag_t                tag_in,           // Egress frame tag
    output egress_tag_t                tag_out,          // Tag after edit
    input  wire logic [NUM_PORTS-1:0][NUM_QUEUES-1:0] queue_pending, // Busy
    input  wire logic [NUM_PORTS-1:0]  sched_pick,       // Grant request
    output logic [NUM_PORTS-1:0]       grant_valid,      // Grant pulse
    output logic [NUM_PORTS-1:0][1:0]  grant_queue,      // Granted queue
    output queue_cfg_t                 queue_cfg [NUM_PORTS][NUM_QUEUES] // Cfg
);
    generate
        if (NUM_PORTS < 1 || NUM_PORTS > 3) begin : g_bad_ports
            $error("NUM_PORTS must lie in 1..3");
        end
    endgenerate

    localparam logic [3:0] LAST_PORT = 4'(NUM_PORTS);

    // Per-port registers
    logic [NUM_PORTS-1:0][1:0] qsel;
    logic [NUM_PORTS-1:0]      vid_replace;
    qcount_t                   qcount [NUM_PORTS];

    // Address decode: every printed offset is a word index
    logic [15:0]  reg_index;
    logic [3:0]   port_field;
    logic [11:0]  reg_off;
    logic         port_hit;
    logic [1:0]   port_idx;
    logic [1:0]   sel_q;
    queue_cfg_t   sel_cfg;
    logic         is_qsel;
    logic         is_qsel_b;
    logic         is_vidrep;
    logic         is_qcount;
    logic         is_ctrl0;
    logic         is_ctrl1;
    logic         is_hi;
    logic         is_lo;
    logic         is_inc;
    logic         reg_hit;
    logic [31:0]  rd_word;
    logic         apb_setup;
    logic         apb_done;
    logic         wr_go;
    logic         wr_lo;
    logic         wr_hi;

    assign reg_index  = paddr[APB_AW-1:2];
    assign port_field = reg_index[15:12];
    assign reg_off    = reg_index[11:0];
    assign port_hit   = (port_field >= FIRST_PORT) &&
                        (port_field <= LAST_PORT);
    assign port_idx   = port_hit ? 2'(port_field - FIRST_PORT) : 2'h0;
    assign sel_q      = qsel[port_idx];
    assign sel_cfg    = queue_cfg[port_idx][sel_q];

    assign is_qsel    = (reg_off == IDX_QSEL);
    assign is_qsel_b  = (reg_off == IDX_QSEL_BYTE);
    assign is_vidrep  = (reg_off == IDX_VIDREP);
    assign is_qcount  = (reg_off == IDX_QCOUNT);
    assign is_ctrl0   = (reg_off == IDX_QCTRL0);
    assign is_ctrl1   = (reg_off == IDX_QCTRL1);
    assign is_hi      = (reg_off == IDX_CRED_HI);
    assign is_lo      = (reg_off == IDX_CRED_LO);
    assign is_inc     = (reg_off == IDX_CRED_INC);
    assign reg_hit    = port_hit && (is_qsel || is_qsel_b || is_vidrep ||
                        is_qcount || is_ctrl0 || is_ctrl1 || is_hi ||
                        is_lo || is_inc);

    // Reserved bits read as zero
    assign rd_word =
        !reg_hit               ? 32'h0 :
        (is_qsel || is_qsel_b) ? {30'h0, qsel[port_idx]} :
        is_vidrep              ? {31'h0, vid_replace[port_idx]} :
        is_qcount              ? {30'h0, qcount[port_idx]} :
        is_ctrl0               ? {24'h0, sel_cfg.sched,
                                  sel_cfg.shaper, 4'h0} :
        is_ctrl1               ? {25'h0, sel_cfg.weight} :
        is_hi                  ? {16'h0, sel_cfg.credit_hi} :
        is_lo                  ? {16'h0, sel_cfg.credit_lo} :
                                 {16'h0, sel_cfg.credit_inc};

    assign apb_setup = psel && !penable;
    assign apb_done  = psel && penable && pready;
    assign wr_go     = apb_done && pwrite && reg_hit;
    assign wr_lo     = wr_go && pstrb[0];
    assign wr_hi     = wr_go && pstrb[1];

    // One wait-free access phase; read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !reg_hit;
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    // Port-wide registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qsel        <= '0;
            vid_replace <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                qcount[p] <= QCNT_FOUR;
            end
        end else if (wr_lo) begin
            if (is_qsel || is_qsel_b) begin
                qsel[port_idx] <= pwdata[1:0];
            end
            if (is_vidrep) begin
                vid_replace[port_idx] <= pwdata[0];
            end
            if (is_qcount) begin
                qcount[port_idx] <= qcount_t'(pwdata[1:0]);
            end
        end
    end

    // Indexed per-queue settings; the selected queue is the target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int q = 0; q < NUM_QUEUES; q++) begin
                    queue_cfg[p][q] <= QUEUE_CFG_RST;
                end
            end
        end else begin
            if (wr_lo && is_ctrl0) begin
                queue_cfg[port_idx][sel_q].sched <=
                    sched_mode_t'(pwdata[7:6]);
                queue_cfg[port_idx][sel_q].shaper <=
                    shaper_mode_t'(pwdata[5:4]);
            end
            if (wr_lo && is_ctrl1) begin
                queue_cfg[port_idx][sel_q].weight <=
                    pwdata[6:0];
            end
            if (is_hi) begin
                if (wr_lo) queue_cfg[port_idx][sel_q].credit_hi[7:0] <=
                    pwdata[7:0];
                if (wr_hi) queue_cfg[port_idx][sel_q].credit_hi[15:8] <=
                    pwdata[15:8];
            end
            if (is_lo) begin
                if (wr_lo) queue_cfg[port_idx][sel_q].credit_lo[7:0] <=
                    pwdata[7:0];
                if (wr_hi) queue_cfg[port_idx][sel_q].credit_lo[15:8] <=
                    pwdata[15:8];
            end
            if (is_inc) begin
                if (wr_lo) queue_cfg[port_idx][sel_q].credit_inc[7:0] <=
                    pwdata[7:0];
                if (wr_hi) queue_cfg[port_idx][sel_q].credit_inc[15:8] <=
                    pwdata[15:8];
            end
        end
    end

    // Egress VID replacement
    egress_tag_t next_tag;
    logic        tag_port_ok;
    logic        tag_replace;
    logic [11:0] tag_pvid;

    assign tag_port_ok = (tag_in.port < 2'(NUM_PORTS));
    assign tag_replace = tag_port_ok && vid_replace[tag_in.port];
    assign tag_pvid    = tag_port_ok ? port_default_vid[tag_in.port]
                                     : 12'h000;

    always_comb begin
        next_tag = tag_in;
        if (tag_replace) begin
            // Zero VID marks priority-only tags, which stay untouched
            if (tag_in.double_tag) begin
                if (tag_in.outer_vid != 12'h000) begin
                    next_tag.outer_vid = tag_pvid;
                end
            end else if (tag_in.inner_vid != 12'h000) begin
                next_tag.inner_vid = tag_pvid;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_out <= '0;
        end else begin
            tag_out <= next_tag;
        end
    end

    // One scheduler per port; queue 0 holds the port-wide mode
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sched
            logic [NUM_QUEUES-1:0][6:0] weights;
            for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_w
                assign weights[q] = queue_cfg[p][q].weight;
            end
            egress_sched u_sched (
                .pclk        (pclk),
                .presetn     (presetn),
                .mode        (queue_cfg[p][0].sched),
                .qcount      (qcount[p]),
                .weights     (weights),
                .pending     (queue_pending[p]),
                .pick        (sched_pick[p]),
                .grant_valid (grant_valid[p]),
                .grant_queue (grant_queue[p])
            );
        end
    endgenerate

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [1:0] chk_data2;
    logic [6:0] chk_data7;
    assign chk_data2 = pwdata[1:0];
    assign chk_data7 = pwdata[6:0];

    sequence s_setup;
        apb_setup;
    endsequence
    sequence s_access_ends;
        pready ##1 !pready;
    endsequence

    property p_apb_answer;
        s_setup |=> s_access_ends;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB access phase did not complete in one cycle");

    property p_qsel_write;
        (wr_lo && is_qsel)
            |=> qsel[$past(port_idx)] == $past(chk_data2);
    endproperty
    a_qsel_write: assert property (p_qsel_write)
        else $error("queue selector did not take written value");

    property p_byte_alias;
        (apb_setup && !pwrite && port_hit && is_qsel_b)
            |=> prdata == {30'h0, qsel[$past(port_idx)]};
    endproperty
    a_byte_alias: assert property (p_byte_alias)
        else $error("byte alias did not read the queue selector");

    property p_weight_write;
        (wr_lo && is_ctrl1)
            |=> queue_cfg[$past(port_idx)][$past(sel_q)].weight ==
                $past(chk_data7);
    endproperty
    a_weight_write: assert property (p_weight_write)
        else $error("weight not stored for the selected queue");

    property p_indexed_read;
        (apb_setup && !pwrite && port_hit && is_hi)
            |=> prdata[15:0] == $past(sel_cfg.credit_hi);
    endproperty
    a_indexed_read: assert property (p_indexed_read)
        else $error("indexed read did not return selected queue copy");

    property p_vid_replace;
        (tag_replace && !tag_in.double_tag && tag_in.inner_vid != 12'h000)
            |=> tag_out.inner_vid == $past(tag_pvid);
    endproperty
    a_vid_replace: assert property (p_vid_replace)
        else $error("non-zero VID was not replaced");

    property p_vid_keep;
        !tag_replace |=> tag_out == $past(tag_in);
    endproperty
    a_vid_keep: assert property (p_vid_keep)
        else $error("tag changed with replacement off");

    property p_vid_outer;
        (tag_replace && tag_in.double_tag && tag_in.outer_vid != 12'h000)
            |=> tag_out.outer_vid == $past(tag_pvid)
                && tag_out.inner_vid == $past(tag_in.inner_vid);
    endproperty
    a_vid_outer: assert property (p_vid_outer)
        else $error("double tagged frame lost its outer VID edit");

    property p_ctrl0_read;
        (apb_setup && !pwrite && port_hit && is_ctrl0)
            |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0;
    endproperty
    a_ctrl0_read: assert property (p_ctrl0_read)
        else $error("mode register reserved bits not zero");
endmodule

// ### tb_top.sv
// Self-checking bench for the egress queue configuration block
`timescale 1ns/1ps
module tb_top;
    import egress_cfg_pkg::*;
    logic                   pclk = 0, presetn = 0;
    logic                   psel = 0, penable = 0, pwrite = 0;
    logic [APB_AW-1:0]      paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rd;
    logic [3:0]             pstrb = 4'hF;
    logic                   pready, pslverr, er, v;
    logic [2:0][11:0]       pvid = '0;
    egress_tag_t            tag_in = '0, tag_out, t;
    logic [2:0][3:0]        pend = '0;
    logic [2:0]             pick = '0, gv, rep;
    logic [2:0][1:0]        gq;
    logic [1:0]             q;
    logic [3:0]             seen;
    queue_cfg_t             qc [3][4];
    logic [7:0]             m_c0 [3][4];
    logic [6:0]             m_w [3][4];
    logic [15:0]            m_hi [3][4], m_lo [3][4], m_inc [3][4];
    int                     error_cnt = 0, samples_checked = 0;

    egress_queue_sched_shaper_cfg #(.NUM_PORTS(3))
        egress_queue_sched_shaper_cfg_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_default_vid(pvid), .tag_in(tag_in), .tag_out(tag_out),
        .queue_pending(pend), .sched_pick(pick), .grant_valid(gv),
        .grant_queue(gq), .queue_cfg(qc));

    always #2.5 pclk = ~pclk;

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Wide enough for a whole queue_cfg_t and for error flag plus data
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [3:0] p,
                       input logic [11:0] o, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {p, o, 2'b00}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Odd queues go through the byte alias of the selector
    task automatic sel(input logic [3:0] p, input logic [1:0] qq);
        apb(1, p, qq[0] ? IDX_QSEL_BYTE : IDX_QSEL,
            {30'h0, qq});
    endtask

    task automatic rdchk(input logic [3:0] p, input logic [11:0] o,
                         input logic [63:0] exp);
        apb(0, p, o, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pick_one(input int p);
        @(posedge pclk);
        pick[p] <= 1'b1;
        @(posedge pclk);
        pick[p] <= 1'b0;
        @(negedge pclk);
        v = gv[p];
        q = gq[p];
        // Return on a rising edge so the caller drives inputs there
        @(posedge pclk);
    endtask

    function automatic egress_tag_t exp_tag(egress_tag_t a);
        egress_tag_t r;
        r = a;
        if (a.port < 3) begin
            if (rep[a.port] && a.double_tag && a.outer_vid != 0) begin
                r.outer_vid = pvid[a.port];
            end else if (rep[a.port] && !a.double_tag && a.inner_vid != 0) begin
                r.inner_vid = pvid[a.port];
            end
        end
        return r;
    endfunction

    // Queue 3 ranks highest under strict priority
    function automatic int exp_top(logic [3:0] pq);
        return pq[3] ? 3 : pq[2] ? 2 : pq[1] ? 1 : 0;
    endfunction

    initial begin
        void'($urandom(32'h4D61));
        do_reset();
        rdchk(1, IDX_QCTRL0, 32'h80);
        rdchk(2, IDX_QSEL, 32'h0);
        // Random per-queue settings, then read back in reverse order
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 4; k++) begin
                m_c0[p][k] = {($urandom % 2) ? 2'b10 : 2'b00, 1'b0,
                              1'($urandom % 2), 4'h0};
                m_w[p][k] = 7'($urandom % 127 + 1);
                m_hi[p][k] = 16'($urandom);
                m_lo[p][k] = 16'($urandom);
                m_inc[p][k] = 16'($urandom);
                sel(4'(p + 1), 2'(k));
                apb(1, 4'(p + 1), IDX_QCTRL0, {24'h0, m_c0[p][k]});
                apb(1, 4'(p + 1), IDX_QCTRL1, {25'h0, m_w[p][k]});
                apb(1, 4'(p + 1), IDX_CRED_HI, {16'h0, m_hi[p][k]});
                apb(1, 4'(p + 1), IDX_CRED_LO, {16'h0, m_lo[p][k]});
                apb(1, 4'(p + 1), IDX_CRED_INC, {16'h0, m_inc[p][k]});
            end
        end
        for (int p = 2; p >= 0; p--) begin
            for (int k = 3; k >= 0; k--) begin
                sel(4'(p + 1), 2'(k));
                rdchk(4'(p + 1), IDX_QSEL_BYTE, 64'(k));
                rdchk(4'(p + 1), IDX_QCTRL0, m_c0[p][k]);
                rdchk(4'(p + 1), IDX_QCTRL1, m_w[p][k]);
                rdchk(4'(p + 1), IDX_CRED_HI, m_hi[p][k]);
                rdchk(4'(p + 1), IDX_CRED_LO, m_lo[p][k]);
                rdchk(4'(p + 1), IDX_CRED_INC, m_inc[p][k]);
                chk(qc[p][k].weight, m_w[p][k]);
            end
        end
        apb(0, 0, IDX_QSEL, 0);
        chk({er, rd}, 33'h1_0000_0000);
        apb(0, 1, 12'h908, 0);
        chk(er, 1'b1);
        // Mid-run reset must restore every queue copy
        do_reset();
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 4; k++) begin
                chk(qc[p][k], QUEUE_CFG_RST);
            end
        end
        // Only the strobed low byte of the high mark may change
        pstrb <= 4'h1;
        apb(1, 1, IDX_CRED_HI, 32'hABCD);
        pstrb <= 4'hF;
        rdchk(1, IDX_CRED_HI, {CRED_HI_RST[15:8], 8'hCD});
        // Egress VID replacement
        rep = 3'b101;
        for (int p = 0; p < 3; p++) begin
            pvid[p] <= 12'($urandom);
            apb(1, 4'(p + 1), IDX_VIDREP, {31'h0, rep[p]});
        end
        rdchk(3, IDX_VIDREP, 32'h1);
        for (int i = 0; i < 40; i++) begin
            t = egress_tag_t'($urandom);
            if (i % 3 == 0) begin
                t.outer_vid = 12'h000;
                t.inner_vid = 12'h000;
            end
            @(posedge pclk);
            tag_in <= t;
            @(posedge pclk);
            @(negedge pclk);
            chk(tag_out, exp_tag(t));
        end
        // Strict priority on port 1: highest pending queue wins
        apb(1, 1, IDX_QCTRL0, 32'h00);
        for (int i = 0; i < 10; i++) begin
            pend[0] <= 4'($urandom % 15 + 1);
            pick_one(0);
            chk(v, 1'b1);
            chk(q, exp_top(pend[0]));
        end
        // Round robin on port 2, weight one: four picks reach all queues
        pend[1] <= 4'hF;
        seen = '0;
        for (int i = 0; i < 4; i++) begin
            pick_one(1);
            chk(v, 1'b1);
            seen[q] = 1'b1;
        end
        chk(seen, 4'hF);
        // Single queue on port 3: only queue 0 is eligible
        apb(1, 3, IDX_QCOUNT, 32'h0);
        pend[2] <= 4'hE;
        pick_one(2);
        chk(v, 1'b0);
        pend[2] <= 4'hF;
        pick_one(2);
        chk({v, q}, 3'b100);
        print_verdict();
    end
endmodule
